// *** rtl/spa_defines.vh ***
// Constants for the serial port: register offsets, field positions,
// reset values and bit-timing counts.
// Assumes inclusion by bare name from the serial port design file.
`ifndef SPA_DEFINES_VH
`define SPA_DEFINES_VH

// Register byte offsets (word aligned)
`define SPA_OFF_CTRL 8'h00
`define SPA_OFF_BUF 8'h04
`define SPA_OFF_PWR 8'h08
`define SPA_OFF_SLAVE_ADDRESS 8'h0C
`define SPA_OFF_MASK 8'h10
`define SPA_OFF_RELOAD 8'h14

// serial_control fields
`define SPA_CTL_RDONE 0
`define SPA_CTL_TDONE 1
`define SPA_CTL_RX9 2
`define SPA_CTL_TX9 3
`define SPA_CTL_REN 4
`define SPA_CTL_MPSEL 5
`define SPA_CTL_MODE1 6
`define SPA_CTL_MODE0 7

// power_control fields
`define SPA_PWR_SPEED 7
`define SPA_PWR_FEACC 6

// Reset values
`define SPA_RST_BYTE 8'h00
`define SPA_RST_RELOAD 16'h0000

// Bit timing: sample states 8, 9 and 10 of 16 are counts 7, 8, 9
`define SPA_SMP_FIRST 4'h7
`define SPA_SMP_SECOND 4'h8
`define SPA_SMP_DECIDE 4'h9
`define SPA_LAST_SLICE 4'hF
`define SPA_SHIFT_DIV 12

`endif

// *** rtl/spa_serial_port.v ***
// Serial port: shift-register mode, asynchronous 10/11-bit modes, framing
// error flag and multiprocessor address recognition, behind an AHB-Lite slave.
// Assumes a single-slave AHB-Lite bus on ref_clk and pins synchronous to it.
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`include "spa_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module spa_serial_port #(
    parameter SHIFT_DIV = `SPA_SHIFT_DIV
) (
    input wire ref_clk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    output reg txdOut,
    input wire rxdIn,
    output reg rxdOut,
    output reg rxdOe
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function vote;
        input a;
        input b;
        input c;
        begin
            vote = (a & b) | (a & c) | (b & c);
        end
    endfunction

    function addrMatch;
        input [7:0] rxByte;
        input [7:0] addr;
        input [7:0] mask;
        reg [7:0] bcast;
        begin
            bcast = addr | mask;
            addrMatch = (((rxByte ^ addr) & mask) == 8'h00)
                || ((rxByte & bcast) == bcast);
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg modeBit0Reg, frameErrReg, mode1Reg, mpSelReg, renReg, tx9Reg;
    reg rx9Reg, tDoneReg, rDoneReg, speedReg, feAccReg;
    reg [7:0] slaveAddrReg, slaveMaskReg, rxBufReg;
    reg [15:0] reloadReg, timerReg;
    reg ovfHalfReg, tDoneSetReg, rDoneSetReg, frameErrSetReg;
    reg dataPhaseReg, dataWriteReg;
    reg [7:0] dataAddrReg;
    reg [31:0] rdNext;

    wire [1:0] mode = {modeBit0Reg, mode1Reg};
    wire asyncMode = (mode != 2'b00);
    wire wrEn = dataPhaseReg & dataWriteReg;
    wire wrCtrl = wrEn & (dataAddrReg == `SPA_OFF_CTRL);
    wire txStart = wrEn & (dataAddrReg == `SPA_OFF_BUF);
    wire addrPhase = hsel & htrans[1] & hready;
    wire [7:0] ctrlView = {feAccReg ? frameErrReg : modeBit0Reg, mode1Reg, mpSelReg,
        renReg, tx9Reg, rx9Reg, tDoneReg, rDoneReg};

    // ------------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY, unmapped reads zero
    // ------------------------------------------------------------------
    always @* begin
        case (haddr[7:0])
            `SPA_OFF_CTRL: rdNext = {24'h000000, ctrlView};
            `SPA_OFF_BUF: rdNext = {24'h000000, rxBufReg};
            `SPA_OFF_PWR: rdNext = {24'h000000, speedReg, feAccReg, 6'h00};
            `SPA_OFF_SLAVE_ADDRESS: rdNext = {24'h000000, slaveAddrReg};
            `SPA_OFF_MASK: rdNext = {24'h000000, slaveMaskReg};
            `SPA_OFF_RELOAD: rdNext = {16'h0000, reloadReg};
            default: rdNext = 32'h00000000;
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            dataPhaseReg <= 1'b0;
            dataWriteReg <= 1'b0;
            dataAddrReg <= 8'h00;
        end else begin
            dataPhaseReg <= addrPhase;
            dataWriteReg <= addrPhase & hwrite;
            if (addrPhase) begin
                dataAddrReg <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
                if (!hwrite)
                    hrdata <= (haddr[31:8] == 24'h000000) ? rdNext : 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Software-visible state; hardware sets win over software clears
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rst) begin
            {modeBit0Reg, frameErrReg, mode1Reg, mpSelReg, renReg, tx9Reg} <= 6'h00;
            {speedReg, feAccReg} <= 2'b00;
            tDoneReg <= 1'b0;
            rDoneReg <= 1'b0;
            slaveAddrReg <= `SPA_RST_BYTE;
            slaveMaskReg <= `SPA_RST_BYTE;
            reloadReg <= `SPA_RST_RELOAD;
        end else begin
            if (wrCtrl) begin
                if (feAccReg)
                    frameErrReg <= hwdata[`SPA_CTL_MODE0] | frameErrSetReg;
                else begin
                    modeBit0Reg <= hwdata[`SPA_CTL_MODE0];
                    if (frameErrSetReg)
                        frameErrReg <= 1'b1;
                end
                mode1Reg <= hwdata[`SPA_CTL_MODE1];
                mpSelReg <= hwdata[`SPA_CTL_MPSEL];
                renReg <= hwdata[`SPA_CTL_REN];
                tx9Reg <= hwdata[`SPA_CTL_TX9];
                tDoneReg <= hwdata[`SPA_CTL_TDONE] | tDoneSetReg;
                rDoneReg <= hwdata[`SPA_CTL_RDONE] | rDoneSetReg;
            end else begin
                if (frameErrSetReg)
                    frameErrReg <= 1'b1;
                if (tDoneSetReg)
                    tDoneReg <= 1'b1;
                if (rDoneSetReg)
                    rDoneReg <= 1'b1;
            end
            if (wrEn && dataAddrReg == `SPA_OFF_PWR) begin
                speedReg <= hwdata[`SPA_PWR_SPEED];
                feAccReg <= hwdata[`SPA_PWR_FEACC];
            end
            if (wrEn && dataAddrReg == `SPA_OFF_SLAVE_ADDRESS)
                slaveAddrReg <= hwdata[7:0];
            if (wrEn && dataAddrReg == `SPA_OFF_MASK)
                slaveMaskReg <= hwdata[7:0];
            if (wrEn && dataAddrReg == `SPA_OFF_RELOAD)
                reloadReg <= hwdata[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Bit-rate timer and 16x tick
    // ------------------------------------------------------------------
    wire timerOvf = (timerReg == 16'hFFFF);
    // Mode 2 runs from the core clock, modes 1 and 3 from timer overflows
    wire tick16 = (mode == 2'b10) ? (speedReg | ovfHalfReg)
        : (timerOvf & (speedReg | ovfHalfReg));

    always @(posedge ref_clk) begin
        if (rst) begin
            timerReg <= `SPA_RST_RELOAD;
            ovfHalfReg <= 1'b0;
        end else begin
            // A reload write restarts the count, so a new rate applies at once
            if (wrEn && dataAddrReg == `SPA_OFF_RELOAD)
                timerReg <= hwdata[15:0];
            else
                timerReg <= timerOvf ? reloadReg : timerReg + 16'h0001;
            if (mode == 2'b10 || timerOvf)
                ovfHalfReg <= ~ovfHalfReg;
        end
    end

    // ------------------------------------------------------------------
    // Transmitter and shift-register engine
    // ------------------------------------------------------------------
    reg [3:0] txSliceReg, txBitsReg, m0BitsReg;
    reg [10:0] txShiftReg;
    reg [7:0] m0RxReg;
    reg [7:0] m0CntReg;
    reg m0ActiveReg, m0TxReg, m0DoneReg;
    wire txRoll = tick16 & (txSliceReg == `SPA_LAST_SLICE);
    wire m0Half = (m0CntReg == SHIFT_DIV / 2 - 1);
    wire m0Wrap = (m0CntReg == SHIFT_DIV - 1);

    always @(posedge ref_clk) begin
        if (rst) begin
            txSliceReg <= 4'h0;
            txBitsReg <= 4'h0;
            txShiftReg <= 11'h7FF;
            txdOut <= 1'b1;
            rxdOut <= 1'b1;
            rxdOe <= 1'b0;
            m0ActiveReg <= 1'b0;
            m0TxReg <= 1'b0;
            m0BitsReg <= 4'h0;
            m0CntReg <= 8'h00;
            m0RxReg <= 8'h00;
            tDoneSetReg <= 1'b0;
        end else begin
            tDoneSetReg <= 1'b0;
            if (tick16)
                txSliceReg <= txSliceReg + 4'h1;
            if (asyncMode) begin
                m0ActiveReg <= 1'b0;
                rxdOe <= 1'b0;
                if (txStart) begin
                    // Frame waits for the next rollover, not the write itself
                    txShiftReg <= (mode == 2'b01) ? {2'b11, hwdata[7:0], 1'b0}
                        : {1'b1, tx9Reg, hwdata[7:0], 1'b0};
                    txBitsReg <= (mode == 2'b01) ? 4'hA : 4'hB;
                end else if (txRoll && txBitsReg != 4'h0) begin
                    txdOut <= txShiftReg[0];
                    txShiftReg <= {1'b1, txShiftReg[10:1]};
                    txBitsReg <= txBitsReg - 4'h1;
                    if (txBitsReg == 4'h1)
                        tDoneSetReg <= 1'b1;
                end else if (txBitsReg == 4'h0) begin
                    txdOut <= 1'b1;
                end
            end else if (!m0ActiveReg) begin
                txdOut <= 1'b1;
                rxdOe <= 1'b0;
                m0CntReg <= 8'h00;
                m0BitsReg <= 4'h0;
                if (txStart) begin
                    txShiftReg <= {3'b111, hwdata[7:0]};
                    m0ActiveReg <= 1'b1;
                    m0TxReg <= 1'b1;
                    rxdOe <= 1'b1;
                    // Flag of a finished byte is still on its way: no restart meanwhile
                end else if (renReg && !rDoneReg && !rDoneSetReg && !m0DoneReg) begin
                    m0ActiveReg <= 1'b1;
                    m0TxReg <= 1'b0;
                end
            end else begin
                m0CntReg <= m0Wrap ? 8'h00 : m0CntReg + 8'h01;
                if (m0Half) begin
                    txdOut <= 1'b0;
                    rxdOut <= txShiftReg[0];
                    txShiftReg <= {1'b1, txShiftReg[10:1]};
                end
                if (m0Wrap) begin
                    txdOut <= 1'b1;
                    if (!m0TxReg)
                        m0RxReg <= {rxdIn, m0RxReg[7:1]};
                    m0BitsReg <= m0BitsReg + 4'h1;
                    if (m0BitsReg == 4'h7) begin
                        m0ActiveReg <= 1'b0;
                        if (m0TxReg)
                            tDoneSetReg <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Asynchronous receiver
    // ------------------------------------------------------------------
    reg rxActiveReg, rxPrevReg, smpAReg, smpBReg;
    reg [3:0] rxSliceReg, rxIdxReg;
    reg [9:0] rxShiftReg;
    wire rxBit = vote(smpAReg, smpBReg, rxdIn);
    wire [3:0] lastIdx = (mode == 2'b01) ? 4'h9 : 4'hA;
    wire [7:0] rxByte = (mode == 2'b01) ? rxShiftReg[9:2] : rxShiftReg[8:1];
    wire rxNinth = (mode == 2'b01) ? rxBit : rxShiftReg[9];
    wire rxAccept = !rDoneReg
        && (!mpSelReg || (rxNinth && addrMatch(rxByte, slaveAddrReg, slaveMaskReg)));

    always @(posedge ref_clk) begin
        if (rst) begin
            rxActiveReg <= 1'b0;
            rxPrevReg <= 1'b1;
            smpAReg <= 1'b1;
            smpBReg <= 1'b1;
            rxSliceReg <= 4'h0;
            rxIdxReg <= 4'h0;
            rxShiftReg <= 10'h000;
            rxBufReg <= `SPA_RST_BYTE;
            rx9Reg <= 1'b0;
            rDoneSetReg <= 1'b0;
            frameErrSetReg <= 1'b0;
            m0DoneReg <= 1'b0;
        end else begin
            rDoneSetReg <= 1'b0;
            frameErrSetReg <= 1'b0;
            // Completion of a shift-register receive
            m0DoneReg <= m0ActiveReg & !m0TxReg & m0Wrap & (m0BitsReg == 4'h7) & !asyncMode;
            if (m0DoneReg) begin
                rxBufReg <= m0RxReg;
                rDoneSetReg <= 1'b1;
            end
            if (wrCtrl)
                rx9Reg <= hwdata[`SPA_CTL_RX9];
            if (tick16)
                rxPrevReg <= rxdIn;
            if (!asyncMode || !renReg) begin
                rxActiveReg <= 1'b0;
            end else if (!rxActiveReg) begin
                if (tick16 && rxPrevReg && !rxdIn) begin
                    rxActiveReg <= 1'b1;
                    rxSliceReg <= 4'h0;
                    rxIdxReg <= 4'h0;
                end
            end else if (tick16) begin
                rxSliceReg <= rxSliceReg + 4'h1;
                if (rxSliceReg == `SPA_SMP_FIRST)
                    smpAReg <= rxdIn;
                if (rxSliceReg == `SPA_SMP_SECOND)
                    smpBReg <= rxdIn;
                if (rxSliceReg == `SPA_SMP_DECIDE) begin
                    rxIdxReg <= rxIdxReg + 4'h1;
                    if (rxIdxReg == 4'h0) begin
                        if (rxBit)
                            rxActiveReg <= 1'b0;
                    end else if (rxIdxReg == lastIdx) begin
                        rxActiveReg <= 1'b0;
                        if (!rxBit)
                            frameErrSetReg <= 1'b1;
                        if (rxAccept) begin
                            rxBufReg <= rxByte;
                            rx9Reg <= rxNinth;
                            rDoneSetReg <= 1'b1;
                        end
                    end else begin
                        rxShiftReg <= {rxBit, rxShiftReg[9:1]};
                    end
                end
            end
        end
    end

endmodule // spa_serial_port
`default_nettype wire

// *** bench/spa_serial_port_chk.sv ***
// Checker for the serial port: bus answers and transmit line timing.
// Assumes it is bound to spa_serial_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module spa_serial_port_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic txdOut,
    input wire logic rxdOe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----
    // Helpers
    // ----
    logic ctlWr_reg;
    logic asyncMode_reg;
    wire logic take = hsel && htrans[1] && hready;
    wire logic rdTake = take && !hwrite;
    // Mode is snooped from control writes, on the same edge as the design
    // takes them; nothing is sent while the mode changes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctlWr_reg <= 1'b0;
            asyncMode_reg <= 1'b0;
        end else begin
            ctlWr_reg <= take && hwrite && haddr == 32'h00000000;
            if (ctlWr_reg) begin
                asyncMode_reg <= hwdata[6];
            end
        end
    end
    sequence s_start;
        asyncMode_reg && $fell(txdOut);
    endsequence
    sequence s_low_run;
        !txdOut [*8];
    endsequence
    // ----
    // Properties
    // ----
    a_start_hold: assert property (s_start |-> s_low_run)
        else $error("start bit shorter than one bit time");
    a_bit_hold: assert property (asyncMode_reg && $changed(txdOut) |=> $stable(txdOut) [*8])
        else $error("transmit line changed between rollovers");
    a_async_no_drive: assert property (asyncMode_reg |-> !rxdOe)
        else $error("receive line driven in asynchronous mode");
    a_idle_after_reset: assert property ($fell(rst) |-> txdOut && !rxdOe)
        else $error("lines not idle after reset");
    a_unmapped_zero: assert property (rdTake && haddr[31:8] != 24'h000000 |=> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (rdTake |=> hrdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_data_stands: assert property (!rdTake |=> $stable(hrdata))
        else $error("read data changed without a read");
    a_okay_ready: assert property (hresp == 1'b0 && hreadyout)
        else $error("bus answer not okay and ready");
    c_start: cover property (s_start);
endmodule // spa_serial_port_chk
`default_nettype wire

// *** bench/spa_far_end.sv ***
// Far-end serial device: sends asynchronous frames on the receive line
// and decodes frames from the transmit line; also plays the shift-register
// partner. Assumes bitClks and shiftMode from the bench.
`timescale 1ns/1ps
`default_nettype none
module spa_far_end (
    input wire logic ref_clk,
    input wire logic txdOut,
    input wire logic dataIn,
    input wire logic dataOe,
    input wire logic shiftMode,
    input wire logic [7:0] bitClks,
    output var logic lineOut
);
    logic [7:0] lastByte;
    logic [7:0] m0Byte;
    logic prevClk = 1'b1;
    logic lastStop;
    int nRx;
    initial begin
        lineOut = 1'b1;
        nRx = 0;
    end
    // Line idles high between frames, as a pulled-up line would
    task automatic send(input logic [7:0] data, input logic stopBit, input logic glitch);
        logic [9:0] frame;
        frame = {stopBit, data, 1'b0};
        @(posedge ref_clk);
        if (glitch) begin
            lineOut <= 1'b0;
            repeat (4) @(posedge ref_clk);
            lineOut <= 1'b1;
            repeat (bitClks) @(posedge ref_clk);
        end
        for (int i = 0; i < 10; i++) begin
            lineOut <= frame[i];
            repeat (bitClks) @(posedge ref_clk);
        end
        lineOut <= 1'b1;
        repeat (bitClks) @(posedge ref_clk);
    endtask
    // Shift-register receive: next bit goes out after each falling shift clock
    task automatic feed(input logic [7:0] data);
        for (int i = 0; i < 8; i++) begin
            do @(posedge ref_clk); while (txdOut !== 1'b0);
            lineOut <= data[i];
            do @(posedge ref_clk); while (txdOut !== 1'b1);
        end
        lineOut <= 1'b1;
    endtask
    // Shift-register transmit: data taken at each rising shift clock
    always @(posedge ref_clk) begin
        prevClk <= txdOut;
        if (dataOe === 1'b1 && prevClk === 1'b0 && txdOut === 1'b1)
            m0Byte <= {dataIn, m0Byte[7:1]};
    end
    // Samples mid-bit, so a late or early bit edge shows as a wrong byte
    always begin
        @(posedge ref_clk);
        if (txdOut === 1'b0 && shiftMode !== 1'b1) begin
            repeat (bitClks / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (bitClks) @(posedge ref_clk);
                lastByte[i] = txdOut;
            end
            repeat (bitClks) @(posedge ref_clk);
            lastStop = txdOut;
            nRx++;
        end
    end
endmodule // spa_far_end
`default_nettype wire

// *** bench/tb_top.sv ***
// Top bench: drives the serial port over AHB-Lite and through the far end.
// Assumes the design, the checker and the far-end model compile first.
`include "spa_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic [7:0] bitClks = 8'h20;
    logic shiftMode = 1'b1;
    wire logic hreadyout, hresp, txdOut, rxdIn, rxdOut, rxdOe;
    wire logic [31:0] hrdata;
    int miscompares = 0;
    int n_checks = 0;
    integer seed = 32'h4B9D8340;
    // Bits: zero mask, glitch, keep flag, multiproc, stop, byte is address
    localparam logic [5:0] CASES [8] = '{6'h02, 6'h0A, 6'h00, 6'h07, 6'h06, 6'h26, 6'h05, 6'h12};
    spa_serial_port spa_serial_port_inst (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .txdOut(txdOut), .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe));
    spa_far_end spa_far_end_inst (.ref_clk(ref_clk), .txdOut(txdOut), .dataIn(rxdOut),
        .dataOe(rxdOe), .shiftMode(shiftMode), .bitClks(bitClks), .lineOut(rxdIn));
    always #50 ref_clk = ~ref_clk;
    // ----
    // Bus and compare tasks
    // ----
    task automatic waitReady();
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        if (k >= 100) miscompares++;
    endtask
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] o, input logic [31:0] d);
        logic [31:0] r;
        bus({24'h000000, o}, 1'b1, d, r);
    endtask
    task automatic rd(input logic [7:0] o, output logic [31:0] r);
        bus({24'h000000, o}, 1'b0, 32'h00000000, r);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkReg(input logic [7:0] o, input logic [31:0] e);
        logic [31:0] r;
        rd(o, r);
        chk(r, e);
    endtask
    function automatic logic addrMatch(input logic [7:0] b, sa, m);
        return (((b ^ sa) & m) == 8'h00) || ((b & (sa | m)) == (sa | m));
    endfunction
    task automatic conclude();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    initial begin
        logic [31:0] r;
        logic [7:0] b, sa, m, expBuf;
        logic expFlag, expErr, acc;
        logic [5:0] cs;
        int k;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) chkReg(8'(i * 4), 32'h00000000);
        bus(32'h00000100, 1'b1, 32'hFFFFFFFF, r);
        bus(32'h00000100, 1'b0, 32'h00000000, r);
        chk(r, 32'h00000000);
        chkReg(8'h18, 32'h00000000);
        // Shift-register mode first: reset leaves mode 0 with receive off
        b = 8'($random(seed));
        wr(`SPA_OFF_BUF, {24'h000000, b});
        k = 0;
        do begin
            rd(`SPA_OFF_CTRL, r);
            k++;
        end while (r[1] !== 1'b1 && k < 100);
        chk(r & 32'h00000002, 32'h00000002);
        chk({24'h000000, spa_far_end_inst.m0Byte}, {24'h000000, b});
        chkReg(`SPA_OFF_BUF, 32'h00000000);
        b = 8'($random(seed));
        wr(`SPA_OFF_CTRL, 32'h00000010);
        spa_far_end_inst.feed(b);
        // Long enough for a wrongly restarted byte to land
        repeat (120) @(posedge ref_clk);
        rd(`SPA_OFF_CTRL, r);
        chk(r & 32'h00000001, 32'h00000001);
        chkReg(`SPA_OFF_BUF, {24'h000000, b});
        shiftMode <= 1'b0;
        sa = 8'($random(seed));
        wr(`SPA_OFF_SLAVE_ADDRESS, {24'h000000, sa});
        chkReg(`SPA_OFF_SLAVE_ADDRESS, {24'h000000, sa});
        wr(`SPA_OFF_RELOAD, 32'h0000FFFE);
        chkReg(`SPA_OFF_RELOAD, 32'h0000FFFE);
        wr(`SPA_OFF_CTRL, 32'h00000050);
        chkReg(`SPA_OFF_CTRL, 32'h00000050);
        // Last frame at 1/32 of overflow rate doubles the bit time
        for (int i = 0; i < 3; i++) begin
            b = 8'($random(seed));
            bitClks <= (i == 2) ? 8'h40 : 8'h20;
            wr(`SPA_OFF_PWR, (i == 2) ? 32'h00000000 : 32'h00000080);
            wr(`SPA_OFF_CTRL, 32'h00000050);
            wr(`SPA_OFF_BUF, {24'h000000, b});
            k = 0;
            do begin
                rd(`SPA_OFF_CTRL, r);
                k++;
            end while (r[1] !== 1'b1 && k < 500);
            chk(r & 32'h00000002, 32'h00000002);
            chk(spa_far_end_inst.nRx, i);
            while (spa_far_end_inst.nRx != i + 1 && k < 2000) begin
                @(posedge ref_clk);
                k++;
            end
            chk({23'h0, spa_far_end_inst.lastStop, spa_far_end_inst.lastByte}, {23'h0, 1'b1, b});
        end
        wr(`SPA_OFF_PWR, 32'h00000080);
        bitClks <= 8'h20;
        expBuf = 8'h00;
        expFlag = 1'b0;
        expErr = 1'b0;
        for (int i = 0; i < 8; i++) begin
            cs = CASES[i];
            sa = 8'($random(seed));
            m = cs[5] ? 8'h00 : 8'($random(seed));
            b = cs[0] ? sa : 8'($random(seed));
            wr(`SPA_OFF_SLAVE_ADDRESS, {24'h000000, sa});
            wr(`SPA_OFF_MASK, {24'h000000, m});
            if (!cs[3]) begin
                wr(`SPA_OFF_CTRL, {24'h000000, 2'b01, cs[2], 5'h10});
                expFlag = 1'b0;
            end
            spa_far_end_inst.send(b, cs[1], cs[4]);
            acc = !expFlag && (!cs[2] || (cs[1] && addrMatch(b, sa, m)));
            expErr = expErr | !cs[1];
            if (acc) expBuf = b;
            expFlag = expFlag | acc;
            rd(`SPA_OFF_CTRL, r);
            chk(r & 32'h00000001, {31'h0, expFlag});
            if (acc) chk(r & 32'h00000004, {29'h0, cs[1], 2'h0});
            chkReg(`SPA_OFF_BUF, {24'h000000, expBuf});
            wr(`SPA_OFF_PWR, 32'h000000C0);
            rd(`SPA_OFF_CTRL, r);
            chk(r & 32'h00000080, {24'h0, expErr, 7'h0});
            wr(`SPA_OFF_PWR, 32'h00000080);
        end
        chkReg(`SPA_OFF_CTRL, {24'h000000, 2'b01, CASES[7][2], 2'b10, CASES[7][1], 1'b0,
            expFlag});
        // Receive enable off: a clean frame must leave flag and buffer alone
        wr(`SPA_OFF_CTRL, 32'h00000040);
        spa_far_end_inst.send(~expBuf, 1'b1, 1'b0);
        rd(`SPA_OFF_CTRL, r);
        chk(r & 32'h00000001, 32'h00000000);
        chkReg(`SPA_OFF_BUF, {24'h000000, expBuf});
        wr(`SPA_OFF_PWR, 32'h000000C0);
        wr(`SPA_OFF_CTRL, 32'h00000050);
        rd(`SPA_OFF_CTRL, r);
        chk(r & 32'h00000080, 32'h00000000);
        conclude();
    end
    // A hang here means a flag or frame never arrived
    initial begin
        #5000000;
        miscompares++;
        conclude();
    end
endmodule // tb_top
bind spa_serial_port spa_serial_port_chk spa_serial_port_chk_inst (.ref_clk(ref_clk),
    .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .txdOut(txdOut), .rxdOe(rxdOe));
`default_nettype wire
